// >>> design/cms_defs.vh
// constants for the move and subtract datapath: register map, fields, encodings, resets
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH

// apb byte offsets, one aligned word each
`define CMS_OFF_INSTR    12'h000
`define CMS_OFF_ACCUM    12'h004
`define CMS_OFF_STATUS   12'h008
`define CMS_OFF_BANK     12'h00C
`define CMS_OFF_PCLATCH  12'h010
`define CMS_OFF_PTR0     12'h014
`define CMS_OFF_PTR1     12'h018
`define CMS_OFF_WDT      12'h01C
`define CMS_OFF_CTRL     12'h020
`define CMS_OFF_MADDR    12'h024
`define CMS_OFF_MDATA    12'h028

// register select codes from the address decoder
`define CMS_SEL_NONE     4'h0
`define CMS_SEL_INSTR    4'h1
`define CMS_SEL_ACCUM    4'h2
`define CMS_SEL_STATUS   4'h3
`define CMS_SEL_BANK     4'h4
`define CMS_SEL_PCLATCH  4'h5
`define CMS_SEL_PTR0     4'h6
`define CMS_SEL_PTR1     4'h7
`define CMS_SEL_WDT      4'h8
`define CMS_SEL_CTRL     4'h9
`define CMS_SEL_MADDR    4'hA
`define CMS_SEL_MDATA    4'hB

// instruction word fields
`define CMS_OP_HI        31
`define CMS_OP_LO        28
`define CMS_DEST_BIT     27
`define CMS_PSEL_BIT     26
`define CMS_MODE_HI      25
`define CMS_MODE_LO      24
`define CMS_LIT_HI       7
`define CMS_FADDR_HI     6
`define CMS_BANK_HI      4
`define CMS_OFFS_HI      5

// opcodes
`define CMS_OPC_NOP      4'h0
`define CMS_OPC_LVP      4'h1
`define CMS_OPC_LVP_REL  4'h2
`define CMS_OPC_LDBANK   4'h3
`define CMS_OPC_LDPAGE   4'h4
`define CMS_OPC_LDACC    4'h5
`define CMS_OPC_STACC    4'h6
`define CMS_OPC_RRC      4'h7
`define CMS_OPC_LSUBA    4'h8
`define CMS_OPC_FSUBA    4'h9
`define CMS_OPC_FSUBAB   4'hA
`define CMS_OPC_SLEEP    4'hB

// status register bit positions
`define CMS_ST_C         0
`define CMS_ST_DC        1
`define CMS_ST_Z         2
`define CMS_ST_PD        3
`define CMS_ST_TO        4

// file addresses that open the indirect windows
`define CMS_F_WIN0       7'h00
`define CMS_F_WIN1       7'h01

// control register bits
`define CMS_CTRL_SLEEP   0

// reset values
`define CMS_RST_BYTE     8'h00
`define CMS_RST_PTR      16'h0000
`define CMS_RST_BANK     5'h00
`define CMS_RST_PAGE     7'h00
`define CMS_RST_STBIT    1'b1
`define CMS_WDT_CLEAR    8'h00
`define CMS_WDT_PRE_DEF  8'h20
`define CMS_PTR_ONE      16'h0001

`endif

// >>> design/cms_sub.v
// two's complement subtractor with carry-in, carry, half carry and zero outputs
`timescale 1ns/1ps
module cms_sub #(
  parameter W = 8
) (
  input  wire [W-1:0] minuend_i,
  input  wire [W-1:0] subtrahend_i,
  input  wire         carry_i,
  output wire [W-1:0] diff_o,
  output wire         carry_o,
  output wire         half_carry_o,
  output wire         zero_o
);

  wire [W:0] full_sum;
  wire [4:0] nib_sum;

  // a - b - borrow computed as a + ~b + carry; carry out high means no borrow
  assign full_sum     = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {{W{1'b0}}, carry_i};
  assign nib_sum      = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + {4'h0, carry_i};
  assign diff_o       = full_sum[W-1:0];
  assign carry_o      = full_sum[W];
  assign half_carry_o = nib_sum[4];
  assign zero_o       = ~|full_sum[W-1:0];

endmodule // cms_sub

// >>> design/cms_core.v
// move and subtract execution datapath with apb register access
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "cms_defs.vh"
module cms_core #(
  parameter       MEM_AW  = 7,
  parameter [7:0] WDT_PRE = `CMS_WDT_PRE_DEF
) (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  output reg         sleep_o
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // address decode shared by the read mux and the write path
  function [3:0] dec_sel;
    input [11:0] a;
    begin
      if (a == `CMS_OFF_INSTR) dec_sel = `CMS_SEL_INSTR;
      else if (a == `CMS_OFF_ACCUM) dec_sel = `CMS_SEL_ACCUM;
      else if (a == `CMS_OFF_STATUS) dec_sel = `CMS_SEL_STATUS;
      else if (a == `CMS_OFF_BANK) dec_sel = `CMS_SEL_BANK;
      else if (a == `CMS_OFF_PCLATCH) dec_sel = `CMS_SEL_PCLATCH;
      else if (a == `CMS_OFF_PTR0) dec_sel = `CMS_SEL_PTR0;
      else if (a == `CMS_OFF_PTR1) dec_sel = `CMS_SEL_PTR1;
      else if (a == `CMS_OFF_WDT) dec_sel = `CMS_SEL_WDT;
      else if (a == `CMS_OFF_CTRL) dec_sel = `CMS_SEL_CTRL;
      else if (a == `CMS_OFF_MADDR) dec_sel = `CMS_SEL_MADDR;
      else if (a == `CMS_OFF_MDATA) dec_sel = `CMS_SEL_MDATA;
      else dec_sel = `CMS_SEL_NONE;
    end
  endfunction

  // window addresses are redirected through the matching pointer
  function [15:0] win_addr;
    input [6:0]  f;
    input [15:0] p0;
    input [15:0] p1;
    begin
      if (f == `CMS_F_WIN0) win_addr = p0;
      else if (f == `CMS_F_WIN1) win_addr = p1;
      else win_addr = {9'h000, f};
    end
  endfunction

  // step a pointer by one; 16-bit arithmetic wraps with no side effect
  function [15:0] ptr_step;
    input [15:0] p;
    input        dec;
    begin
      if (dec) ptr_step = p - `CMS_PTR_ONE;
      else ptr_step = p + `CMS_PTR_ONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [7:0]        mem [0:(1<<MEM_AW)-1];
  reg [31:0]       instr_q;
  reg [7:0]        acc_q,     acc_d;
  reg              c_q,       c_d;
  reg              dc_q,      dc_d;
  reg              z_q,       z_d;
  reg              pd_q,      pd_d;
  reg              to_q,      to_d;
  reg [4:0]        bank_q,    bank_d;
  reg [6:0]        page_q,    page_d;
  reg [15:0]       ptr0_q,    ptr0_d;
  reg [15:0]       ptr1_q,    ptr1_d;
  reg [7:0]        wdt_q;
  reg [7:0]        pre_q;
  reg              sleep_d;
  reg              wdt_clr;
  reg [MEM_AW-1:0] maddr_q,   maddr_d;
  reg              mem_we;
  reg [MEM_AW-1:0] mem_wa;
  reg [7:0]        mem_wd;
  reg [15:0]       exec_addr;
  reg [15:0]       ptr_new;
  reg [31:0]       rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // apb qualifiers and instruction fields

  wire        acc_phase = psel_i & penable_i;
  wire        wr_go     = acc_phase & pready_o & pwrite_i;
  wire [3:0]  sel       = dec_sel(paddr_i);
  wire [3:0]  opc       = pwdata_i[`CMS_OP_HI:`CMS_OP_LO];
  wire        dest      = pwdata_i[`CMS_DEST_BIT];
  wire        pick1     = pwdata_i[`CMS_PSEL_BIT];
  wire [1:0]  mode      = pwdata_i[`CMS_MODE_HI:`CMS_MODE_LO];
  wire [7:0]  lit       = pwdata_i[`CMS_LIT_HI:0];
  wire [6:0]  faddr     = pwdata_i[`CMS_FADDR_HI:0];
  wire [5:0]  offs      = pwdata_i[`CMS_OFFS_HI:0];
  wire [15:0] ptr_cur   = pick1 ? ptr1_q : ptr0_q;
  wire        exec_go   = wr_go & (sel == `CMS_SEL_INSTR) & ~sleep_o;

  // operand address: pointer based for loads, window-resolved for file operands
  always @* begin
    ptr_new   = ptr_step(ptr_cur, mode[0]);
    exec_addr = win_addr(faddr, ptr0_q, ptr1_q);
    if (opc == `CMS_OPC_LVP) begin
      exec_addr = mode[1] ? ptr_cur : ptr_new;
    end else if (opc == `CMS_OPC_LVP_REL) begin
      exec_addr = ptr_cur + {{10{offs[5]}}, offs};
    end
  end

  wire [7:0] fval = mem[exec_addr[MEM_AW-1:0]];
  wire [7:0] mval = mem[maddr_q];

  ////////////////////////////////////////////////////////////////////////////
  // subtractor shared by the three subtract forms

  wire [7:0] sub_res;
  wire       sub_c;
  wire       sub_dc;
  wire       sub_z;
  wire [7:0] sub_a   = (opc == `CMS_OPC_LSUBA) ? lit : fval;
  wire       sub_cin = (opc == `CMS_OPC_FSUBAB) ? c_q : 1'b1;

  cms_sub #(
    .W(8)
  ) u_sub (
    .minuend_i    (sub_a),
    .subtrahend_i (acc_q),
    .carry_i      (sub_cin),
    .diff_o       (sub_res),
    .carry_o      (sub_c),
    .half_carry_o (sub_dc),
    .zero_o       (sub_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  // execution and direct register writes; only one apb write at a time, so
  // an instruction and a direct write never collide

  always @* begin
    acc_d   = acc_q;
    c_d     = c_q;
    dc_d    = dc_q;
    z_d     = z_q;
    pd_d    = pd_q;
    to_d    = to_q;
    bank_d  = bank_q;
    page_d  = page_q;
    ptr0_d  = ptr0_q;
    ptr1_d  = ptr1_q;
    maddr_d = maddr_q;
    sleep_d = sleep_o;
    wdt_clr = 1'b0;
    mem_we  = 1'b0;
    mem_wa  = exec_addr[MEM_AW-1:0];
    mem_wd  = acc_q;
    if (exec_go) begin
      case (opc)
        `CMS_OPC_LVP: begin
          acc_d = fval;
          z_d   = ~|fval;
          if (pick1) ptr1_d = ptr_new;
          else ptr0_d = ptr_new;
        end
        `CMS_OPC_LVP_REL: begin
          acc_d = fval;
          z_d   = ~|fval;
        end
        `CMS_OPC_LDBANK: begin
          bank_d = pwdata_i[`CMS_BANK_HI:0];
        end
        `CMS_OPC_LDPAGE: begin
          page_d = faddr;
        end
        `CMS_OPC_LDACC: begin
          acc_d = lit;
        end
        `CMS_OPC_STACC: begin
          mem_we = 1'b1;
        end
        `CMS_OPC_RRC: begin
          c_d    = fval[0];
          mem_wd = {c_q, fval[7:1]};
          if (dest) mem_we = 1'b1;
          else acc_d = {c_q, fval[7:1]};
        end
        `CMS_OPC_LSUBA: begin
          acc_d = sub_res;
          c_d   = sub_c;
          dc_d  = sub_dc;
          z_d   = sub_z;
        end
        `CMS_OPC_FSUBA, `CMS_OPC_FSUBAB: begin
          c_d    = sub_c;
          dc_d   = sub_dc;
          z_d    = sub_z;
          mem_wd = sub_res;
          if (dest) mem_we = 1'b1;
          else acc_d = sub_res;
        end
        `CMS_OPC_SLEEP: begin
          wdt_clr = 1'b1;
          sleep_d = 1'b1;
          pd_d    = 1'b0;
          to_d    = 1'b1;
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end else if (wr_go) begin
      if (sel == `CMS_SEL_ACCUM) begin
        acc_d = pwdata_i[7:0];
      end else if (sel == `CMS_SEL_STATUS) begin
        c_d  = pwdata_i[`CMS_ST_C];
        dc_d = pwdata_i[`CMS_ST_DC];
        z_d  = pwdata_i[`CMS_ST_Z];
      end else if (sel == `CMS_SEL_BANK) begin
        bank_d = pwdata_i[`CMS_BANK_HI:0];
      end else if (sel == `CMS_SEL_PCLATCH) begin
        page_d = pwdata_i[6:0];
      end else if (sel == `CMS_SEL_PTR0) begin
        ptr0_d = pwdata_i[15:0];
      end else if (sel == `CMS_SEL_PTR1) begin
        ptr1_d = pwdata_i[15:0];
      end else if (sel == `CMS_SEL_CTRL) begin
        if (pwdata_i[`CMS_CTRL_SLEEP]) sleep_d = 1'b0; // wake request
      end else if (sel == `CMS_SEL_MADDR) begin
        maddr_d = pwdata_i[MEM_AW-1:0];
      end else if (sel == `CMS_SEL_MDATA) begin
        mem_we = 1'b1;
        mem_wa = maddr_q;
        mem_wd = pwdata_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural registers

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      instr_q <= 32'h00000000;
      acc_q   <= `CMS_RST_BYTE;
      c_q     <= 1'b0;
      dc_q    <= 1'b0;
      z_q     <= 1'b0;
      pd_q    <= `CMS_RST_STBIT;
      to_q    <= `CMS_RST_STBIT;
      bank_q  <= `CMS_RST_BANK;
      page_q  <= `CMS_RST_PAGE;
      ptr0_q  <= `CMS_RST_PTR;
      ptr1_q  <= `CMS_RST_PTR;
      maddr_q <= {MEM_AW{1'b0}};
      sleep_o <= 1'b0;
    end else begin
      if (exec_go) instr_q <= pwdata_i;
      acc_q   <= acc_d;
      c_q     <= c_d;
      dc_q    <= dc_d;
      z_q     <= z_d;
      pd_q    <= pd_d;
      to_q    <= to_d;
      bank_q  <= bank_d;
      page_q  <= page_d;
      ptr0_q  <= ptr0_d;
      ptr1_q  <= ptr1_d;
      maddr_q <= maddr_d;
      sleep_o <= sleep_d;
    end
  end

  // data memory has no reset; software must initialise what it reads
  always @(posedge clk_sys_i) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: prescaler makes a one-cycle tick, counter wraps freely

  wire pre_tick = (pre_q == WDT_PRE - 8'h01);

  always @(posedge clk_sys_i) begin
    if (reset_i || wdt_clr) begin
      pre_q <= `CMS_WDT_CLEAR;
      wdt_q <= `CMS_WDT_CLEAR;
    end else begin
      pre_q <= pre_tick ? `CMS_WDT_CLEAR : pre_q + 8'h01;
      if (pre_tick) wdt_q <= wdt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read mux and response; one wait state keeps every output registered

  always @* begin
    rd_mux = 32'h00000000;
    if (sel == `CMS_SEL_INSTR) rd_mux = instr_q;
    else if (sel == `CMS_SEL_ACCUM) rd_mux = {24'h000000, acc_q};
    else if (sel == `CMS_SEL_STATUS) rd_mux = {27'h0000000, to_q, pd_q, z_q, dc_q, c_q};
    else if (sel == `CMS_SEL_BANK) rd_mux = {27'h0000000, bank_q};
    else if (sel == `CMS_SEL_PCLATCH) rd_mux = {25'h0000000, page_q};
    else if (sel == `CMS_SEL_PTR0) rd_mux = {16'h0000, ptr0_q};
    else if (sel == `CMS_SEL_PTR1) rd_mux = {16'h0000, ptr1_q};
    else if (sel == `CMS_SEL_WDT) rd_mux = {24'h000000, wdt_q};
    else if (sel == `CMS_SEL_CTRL) rd_mux = {31'h00000000, sleep_o};
    else if (sel == `CMS_SEL_MADDR) rd_mux = {{(32-MEM_AW){1'b0}}, maddr_q};
    else if (sel == `CMS_SEL_MDATA) rd_mux = {24'h000000, mval};
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= acc_phase & ~pready_o;
      pslverr_o <= acc_phase & ~pready_o & (sel == `CMS_SEL_NONE);
      if (acc_phase & ~pready_o & ~pwrite_i) prdata_o <= rd_mux;
      else prdata_o <= 32'h00000000;
    end
  end

endmodule // cms_core

// >>> test/cms_core_assertions.sv
// checker for cms_core: apb answer timing, sleep handshake and register widths
`timescale 1ns/1ps
`include "cms_defs.vh"
module cms_chk #(
  parameter       MEM_AW  = 7,
  parameter [7:0] WDT_PRE = 8'h20
) (
  input wire        clk_sys_i,
  input wire        reset_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        sleep_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  // completed transfers and the sleep controls they carry
  wire done = psel_i && penable_i && pready_o;
  wire rd   = done && !pwrite_i;
  wire nap  = done && pwrite_i && paddr_i == `CMS_OFF_INSTR
              && pwdata_i[31:28] == `CMS_OPC_SLEEP && !sleep_o;
  wire wake = done && pwrite_i && paddr_i == `CMS_OFF_CTRL && pwdata_i[0];
  ////////////////////////////////////////
  AST_ONE_WAIT:
    assert property (psel_i && !penable_i ##1 psel_i && penable_i |-> !pready_o ##1 pready_o)
    else $error("pready not in second access cycle");
  AST_ERR_PAIR:
    assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  AST_UNMAPPED:
    assert property (done && paddr_i > `CMS_OFF_MDATA |-> pslverr_o)
    else $error("unmapped address not refused");
  AST_IDLE_DATA:
    assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside answer");
  AST_SLEEP_GO:
    assert property (nap |=> sleep_o) else $error("sleep instruction did not halt");
  AST_SLEEP_CAUSE:
    assert property ($rose(sleep_o) |-> $past(nap)) else $error("halt without sleep instruction");
  AST_SLEEP_HOLD:
    assert property (sleep_o && !wake |=> sleep_o) else $error("left sleep without wake write");
  AST_WAKE:
    assert property (wake |=> !sleep_o) else $error("wake write ignored");
  AST_BANK_W:
    assert property (rd && paddr_i == `CMS_OFF_BANK |-> prdata_o[31:5] == 27'h0)
    else $error("bank select wider than five bits");
  AST_PAGE_W:
    assert property (rd && paddr_i == `CMS_OFF_PCLATCH |-> prdata_o[31:7] == 25'h0)
    else $error("page latch wider than seven bits");
  AST_ACC_W:
    assert property (rd && paddr_i == `CMS_OFF_ACCUM |-> prdata_o[31:8] == 24'h0)
    else $error("accumulator wider than eight bits");
  AST_PTR_W:
    assert property (rd && (paddr_i == `CMS_OFF_PTR0 || paddr_i == `CMS_OFF_PTR1)
                     |-> prdata_o[31:16] == 16'h0) else $error("pointer wider than 16 bits");
  // main scenarios seen
  COV_NAP:  cover property (nap);
  COV_WAKE: cover property (wake && sleep_o);
  COV_ERR:  cover property (pslverr_o);
endmodule // cms_chk

bind cms_core cms_chk #(.MEM_AW(MEM_AW), .WDT_PRE(WDT_PRE)) u_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_o(sleep_o));

// >>> test/cms_core_tb.sv
// self-checking bench for the move and subtract datapath
`timescale 1ns/1ps
`include "cms_defs.vh"
module cms_core_tb;
  reg         clk_sys_i = 1'b0;
  reg         reset_i   = 1'b1;
  reg         psel_i    = 1'b0;
  reg         penable_i = 1'b0;
  reg         pwrite_i  = 1'b0;
  reg  [11:0] paddr_i   = 12'h000;
  reg  [31:0] pwdata_i  = 32'h0;
  wire [31:0] prdata_o;
  wire        pready_o;
  wire        pslverr_o;
  wire        sleep_o;
  integer     num_errors  = 0;
  integer     comparisons = 0;
  integer     seed        = 97;
  integer     i;
  reg  [31:0] rd, m;
  reg  [11:0] ad;
  reg  [9:0]  e;
  reg  [7:0]  a, v, k, f, res;
  reg  [15:0] p, ea, np;
  reg  [3:0]  op;
  reg  [2:0]  st, es;
  reg  [1:0]  mm;
  reg         er, dd, pn;
  // short watchdog prescale; the post-sleep count is still read before its first tick
  cms_core #(.MEM_AW(7), .WDT_PRE(8'h08)) dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_o(sleep_o));
  ////////////////////////////////////////
  // 20 MHz clock
  always #25 clk_sys_i = ~clk_sys_i;
  task chk(input [63:0] nm, input [31:0] x, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (x !== g) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h got %h", nm, x, g);
      end
    end
  endtask
  // one apb transfer: the request stands until pready is seen at an edge
  task apb(input w, input [11:0] ad_i, input [31:0] d);
    integer t;
    begin
      @(posedge clk_sys_i);
      psel_i    <= 1'b1;
      pwrite_i  <= w;
      paddr_i   <= ad_i;
      pwdata_i  <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      t = 0;
      @(posedge clk_sys_i);
      // no local limit: only the hang guard may end a wait
      while (pready_o !== 1'b1) begin
        @(posedge clk_sys_i);
        t = t + 1;
      end
      chk("waits", 32'h1, t);
      rd = prdata_o;
      er = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task wr(input [11:0] x, input [31:0] d); apb(1'b1, x, d); endtask
  task rdr(input [11:0] x); apb(1'b0, x, 32'h0); endtask
  task exec(input [31:0] w); apb(1'b1, `CMS_OFF_INSTR, w); endtask
  task mset(input [7:0] x, input [7:0] d);
    begin
      wr(`CMS_OFF_MADDR, {24'h0, x});
      wr(`CMS_OFF_MDATA, {24'h0, d});
    end
  endtask
  task mget(input [7:0] x);
    begin
      wr(`CMS_OFF_MADDR, {24'h0, x});
      rdr(`CMS_OFF_MDATA);
    end
  endtask
  function [31:0] ins(input [3:0] o, input d, input n, input [1:0] md, input [7:0] l);
    ins = {o, d, n, md, 16'h0000, l};
  endfunction
  // {carry, half carry, difference}; carry means no borrow
  function [9:0] fsub(input [7:0] x, input [7:0] y, input ci);
    reg [4:0] lo;
    reg [8:0] s;
    begin
      lo = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, ci};
      s = {1'b0, x} + {1'b0, ~y} + {8'h00, ci};
      fsub = {s[8], lo[4], s[7:0]};
    end
  endfunction
  task summarize;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  // hang guard, far above the few thousand cycles the run needs
  initial begin
    #(50 * 40000);
    chk("watchdog", 0, 1);
    summarize;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (ad = 12'h004; ad < 12'h01C; ad = ad + 12'h004) begin
      rdr(ad);
      chk("reset", (ad == `CMS_OFF_STATUS) ? 32'h18 : 32'h0, rd);
    end
    rdr(12'h02C);
    chk("slverr", 32'h1, {31'h0, er});
    chk("unmapped", 32'h0, rd);
    // literal loads leave the flags alone; first pass uses all-ones literals
    for (i = 0; i < 6; i = i + 1) begin
      m = $random(seed);
      k = (i == 0) ? 8'hFF : m[7:0];
      st = m[10:8];
      wr(`CMS_OFF_STATUS, {29'h0, st});
      exec(ins(`CMS_OPC_LDBANK, 1'b0, 1'b0, 2'b00, k));
      exec(ins(`CMS_OPC_LDPAGE, 1'b0, 1'b0, 2'b00, k));
      exec(ins(`CMS_OPC_LDACC, 1'b0, 1'b0, 2'b00, k));
      rdr(`CMS_OFF_BANK);
      chk("bank", {27'h0, k[4:0]}, rd);
      rdr(`CMS_OFF_PCLATCH);
      chk("page", {25'h0, k[6:0]}, rd);
      rdr(`CMS_OFF_ACCUM);
      chk("acc", {24'h0, k}, rd);
      rdr(`CMS_OFF_STATUS);
      chk("flags", {27'h3, st}, rd);
    end
    // subtract and rotate forms, both destinations, against bench arithmetic
    for (i = 0; i < 40; i = i + 1) begin
      m = $random(seed);
      a = m[7:0];
      v = (i == 0) ? a : m[15:8];
      st = m[18:16];
      dd = m[19];
      m = {$random(seed)} % 126;
      f = m[7:0] + 8'h02;
      op = (i[1:0] == 2'b11) ? `CMS_OPC_RRC : `CMS_OPC_LSUBA + {2'b00, i[1:0]};
      if (op == `CMS_OPC_LSUBA) dd = 1'b0;
      mset(f, v);
      exec(ins(`CMS_OPC_LDACC, 1'b0, 1'b0, 2'b00, a));
      wr(`CMS_OFF_STATUS, {29'h0, st});
      exec(ins(op, dd, 1'b0, 2'b00, (op == `CMS_OPC_LSUBA) ? v : f));
      e = fsub(v, a, (op == `CMS_OPC_FSUBAB) ? st[0] : 1'b1);
      res = (op == `CMS_OPC_RRC) ? {st[0], v[7:1]} : e[7:0];
      es = (op == `CMS_OPC_RRC) ? {st[2:1], v[0]} : {e[7:0] == 8'h00, e[8], e[9]};
      rdr(`CMS_OFF_ACCUM);
      chk("acc", {24'h0, dd ? a : res}, rd);
      mget(f);
      chk("file", {24'h0, dd ? res : v}, rd);
      rdr(`CMS_OFF_STATUS);
      chk("flags", {27'h3, es}, rd);
    end
    // pointer loads: each update mode at a wrap corner, then relative offsets
    for (i = 0; i < 12; i = i + 1) begin
      m = $random(seed);
      pn = i[0];
      mm = i[2:1];
      v = (i == 0) ? 8'h00 : m[31:24];
      k = (i == 8) ? 8'h20 : (i == 9) ? 8'h1F : {2'b00, m[5:0]};
      p = (i > 7) ? m[23:8] : (mm[0] ? 16'h0000 : 16'hFFFF);
      ea = (mm == 2'b00) ? p + 16'h1 : (mm == 2'b01) ? p - 16'h1 : p;
      np = mm[0] ? p - 16'h1 : p + 16'h1;
      if (i > 7) ea = p + {{10{k[5]}}, k[5:0]};
      if (i > 7) np = p;
      wr(pn ? `CMS_OFF_PTR1 : `CMS_OFF_PTR0, {16'h0, p});
      mset({1'b0, ea[6:0]}, v);
      exec(ins((i > 7) ? `CMS_OPC_LVP_REL : `CMS_OPC_LVP, 1'b0, pn, mm, k));
      rdr(`CMS_OFF_ACCUM);
      chk("ptrload", {24'h0, v}, rd);
      rdr(pn ? `CMS_OFF_PTR1 : `CMS_OFF_PTR0);
      chk("pointer", {16'h0, np}, rd);
      rdr(`CMS_OFF_STATUS);
      chk("zero", {31'h0, v == 8'h00}, {31'h0, rd[2]});
    end
    // store at the top file address and through pointer 1's window
    a = 8'hC3;
    exec(ins(`CMS_OPC_LDACC, 1'b0, 1'b0, 2'b00, a));
    exec(ins(`CMS_OPC_STACC, 1'b0, 1'b0, 2'b00, 8'h7F));
    mget(8'h7F);
    chk("store", {24'h0, a}, rd);
    wr(`CMS_OFF_PTR1, 32'h0000_1234);
    exec(ins(`CMS_OPC_STACC, 1'b0, 1'b0, 2'b00, 8'h01));
    mget(8'h34);
    chk("window", {24'h0, a}, rd);
    // a no-operation word is kept as the last instruction and moves nothing
    exec(ins(`CMS_OPC_NOP, 1'b0, 1'b0, 2'b00, 8'h5A));
    rdr(`CMS_OFF_INSTR);
    chk("instr", ins(`CMS_OPC_NOP, 1'b0, 1'b0, 2'b00, 8'h5A), rd);
    rdr(`CMS_OFF_ACCUM);
    chk("nop", {24'h0, a}, rd);
    // sleep: watchdog cleared, power-down flag cleared and time-out flag set, core ignores work until woken
    wr(`CMS_OFF_STATUS, 32'h5);
    exec(ins(`CMS_OPC_SLEEP, 1'b0, 1'b0, 2'b00, 8'h00));
    rdr(`CMS_OFF_WDT);
    chk("wdt", 32'h0, rd);
    chk("asleep", 1, {31'h0, sleep_o});
    rdr(`CMS_OFF_STATUS);
    chk("pwrflags", 32'h15, rd);
    exec(ins(`CMS_OPC_LDACC, 1'b0, 1'b0, 2'b00, 8'h77));
    rdr(`CMS_OFF_ACCUM);
    chk("halted", {24'h0, a}, rd);
    rdr(`CMS_OFF_INSTR);
    chk("lastins", ins(`CMS_OPC_SLEEP, 1'b0, 1'b0, 2'b00, 8'h00), rd);
    wr(`CMS_OFF_CTRL, 32'h1);
    rdr(`CMS_OFF_CTRL);
    chk("awake", 32'h0, {rd[31:1], sleep_o});
    summarize;
  end
endmodule // cms_core_tb
